/* File: verification/dcs_nv_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Non-volatile store facing the sequencer; keeps data over resets.
// ****************************************************************
module dcs_nv_model #(
  parameter logic [31:0] BOOT_KEY = dcs_pkg::KEY_DEFAULT
) (
  input  wire logic                 clk,
  input  wire dcs_pkg::dcs_nv_req_s nv_req_q,
  output logic [31:0]               key_q,
  output logic [2:0]                ptype_q,
  output logic [3:0]                erased_q
);
  initial key_q = BOOT_KEY;
  initial ptype_q = dcs_pkg::PT_RESET;
  initial erased_q = 4'h0;
  always @(posedge clk) begin
    if (nv_req_q.store) begin
      key_q <= nv_req_q.key;
      ptype_q <= nv_req_q.ptype;
    end
    if (nv_req_q.erase_all)
      key_q <= dcs_pkg::KEY_DEFAULT;
    if (nv_req_q.seg_erase)
      erased_q <= nv_req_q.seg;
  end
endmodule // dcs_nv_model

/* File: verification/dcs_seq_sva.sv */
`timescale 1ns/1ns
// ****************************************************************
// Port checker for the command sequencer.
// ****************************************************************
module dcs_seq_sva (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   ce,
  input wire logic [3:0]             addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr,
  input wire dcs_pkg::dcs_nv_req_s   nv_req_q,
  input wire logic                   buf_exec_en,
  input wire dcs_pkg::dcs_seg_load_s seg_load_q,
  input wire logic                   line_next_q,
  input wire logic                   upload_go_q,
  input wire logic                   save_go_q,
  input wire logic                   count_up_q,
  input wire logic                   count_dn_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Decode of a taken command write and its opcode.
  wire       cmd_wr = ce && wr && addr == dcs_pkg::REG_CMD;
  wire [3:0] op     = wdata[3:0];
  wire       call_ok = cmd_wr && op == dcs_pkg::OP_CALL && wdata[8] &&
                       wdata[7:4] != 4'h0 && wdata[7:4] <= dcs_pkg::SEG_MAX;
  a_pause_stop: assert property (
    $fell(buf_exec_en) |-> $past(cmd_wr && op == dcs_pkg::OP_PAUSE))
    else $error("execution stopped without pause");
  a_resume_run: assert property (
    $rose(buf_exec_en) |-> $past(cmd_wr && op == dcs_pkg::OP_RESUME))
    else $error("execution resumed without resume");
  a_upload_cause: assert property (
    upload_go_q && $past(ce) |-> $past(cmd_wr && op == dcs_pkg::OP_UPLOAD))
    else $error("upload pulse without upload command");
  a_save_cause: assert property (
    save_go_q && $past(ce) |-> $past(cmd_wr && op == dcs_pkg::OP_SAVE))
    else $error("save pulse without save command");
  // segment erase follows a delete of a legal segment.
  a_erase_cause: assert property (
    nv_req_q.seg_erase && $past(ce) |-> $past(cmd_wr &&
    op == dcs_pkg::OP_DELETE) && nv_req_q.seg == $past(wdata[7:4]))
    else $error("segment erase without matching delete");
  a_erase_range: assert property (
    nv_req_q.seg_erase |-> nv_req_q.seg inside {[4'h1:4'hc]})
    else $error("segment erase outside legal range");
  // call loads named segment or is ignored.
  a_call_load: assert property (
    call_ok |=> line_next_q || (seg_load_q.valid && seg_load_q.line ==
    dcs_pkg::LINE_FIRST && seg_load_q.seg == $past(wdata[7:4])))
    else $error("call did not load segment at line one");
  a_return_load: assert property (
    cmd_wr && op == dcs_pkg::OP_CALL && !wdata[8] |=>
    seg_load_q.valid != line_next_q)
    else $error("return neither reloaded nor stepped on");
  a_count_excl: assert property (
    !(count_up_q && count_dn_q))
    else $error("up and down count together");
endmodule // dcs_seq_sva

bind dcs_sequencer dcs_seq_sva u_sva (.clk, .nrst, .ce, .addr, .wdata,
  .wr, .nv_req_q, .buf_exec_en, .seg_load_q, .line_next_q, .upload_go_q,
  .save_go_q, .count_up_q, .count_dn_q);

/* File: verification/tb.sv */
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench for the command sequencer.
// ****************************************************************
module tb;
  logic clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0;
  logic pulse_a = 0, pulse_b = 0;
  logic [3:0] addr = 4'h0, cur_seg = 4'h0, erased;
  logic [5:0] cur_line = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata_q, nv_key_in, v;
  logic [2:0] nv_ptype_in;
  logic buf_exec_en, buf_accept, line_next_q, upload_go_q, save_go_q;
  logic count_up_q, count_dn_q;
  dcs_pkg::dcs_nv_req_s nv_req_q;
  dcs_pkg::dcs_seg_load_s seg_load_q;
  int miscompares = 0, total_checks = 0, cyc = 0;

  dcs_sequencer uut (.clk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata_q,
    .nv_key_in, .nv_ptype_in, .nv_req_q, .buf_exec_en, .buf_accept,
    .cur_seg, .cur_line, .seg_load_q, .line_next_q, .upload_go_q,
    .save_go_q, .pulse_a, .pulse_b, .count_up_q, .count_dn_q);
  dcs_nv_model nv (.clk, .nv_req_q, .key_q(nv_key_in),
    .ptype_q(nv_ptype_in), .erased_q(erased));

  // Clock and hang guard.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] seen, exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task pwr;
    @(posedge clk) nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task cmd(input logic [3:0] op, input logic [3:0] arg, input logic ha);
    wrr(dcs_pkg::REG_CMD, {23'h0, ha, arg, op});
  endtask
  task pls(input logic a, b, input logic [31:0] eu, ed);
    logic [31:0] nu, nd;
    nu = 0;
    nd = 0;
    @(posedge clk);
    pulse_a <= a;
    pulse_b <= b;
    repeat (4) begin
      @(posedge clk) #1;
      nu = nu + count_up_q;
      nd = nd + count_dn_q;
    end
    @(posedge clk);
    pulse_a <= 1'b0;
    pulse_b <= 1'b0;
    repeat (4) @(posedge clk);
    chk(nu, eu, "up count");
    chk(nd, ed, "down count");
  endtask

  task t_pause;
    cmd(dcs_pkg::OP_PAUSE, 4'h0, 1'b0);
    chk(buf_exec_en, 0, "paused");
    chk(buf_accept, 1, "accepting");
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_PAUSED], 1, "paused flag");
    cmd(dcs_pkg::OP_RESUME, 4'h0, 1'b0);
    chk(buf_exec_en, 1, "resumed");
    @(posedge clk) ce <= 1'b0;
    cmd(dcs_pkg::OP_PAUSE, 4'h0, 1'b0);
    @(posedge clk) ce <= 1'b1;
    chk(buf_exec_en, 1, "frozen pause");
    $display("test pause done");
  endtask
  task t_pulse;
    logic [2:0] ty [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    logic eu [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    wrr(dcs_pkg::REG_MODE, {28'h0, dcs_pkg::MODE_PULSE_FOLLOW});
    for (int i = 0; i < 5; i++) begin
      wrr(dcs_pkg::REG_PTYPE, {29'h0, ty[i]});
      rdr(dcs_pkg::REG_PTYPE, v);
      chk(v, {29'h0, ty[i]}, "type readback");
      pls(1'b1, 1'b0, eu[i], !eu[i]);
    end
    wrr(dcs_pkg::REG_PTYPE, {29'h0, dcs_pkg::PT_CW_CCW});
    pls(1'b0, 1'b1, 0, 1);
    wrr(dcs_pkg::REG_PTYPE, 32'h0000_0003);
    rdr(dcs_pkg::REG_PTYPE, v);
    chk(v, {29'h0, dcs_pkg::PT_CW_CCW}, "bad type kept");
    wrr(dcs_pkg::REG_MODE, {28'h0, dcs_pkg::MODE_RESET});
    pls(1'b1, 1'b0, 0, 0);
    $display("test pulse done");
  endtask
  task t_lock;
    cmd(dcs_pkg::OP_UPLOAD, 4'h0, 1'b0);
    chk(upload_go_q, 1, "open upload");
    wrr(dcs_pkg::REG_KEY, 32'h3939_6b61);
    cmd(dcs_pkg::OP_KEY, 4'h0, 1'b0);
    cmd(dcs_pkg::OP_STORE, 4'h0, 1'b0);
    chk(nv_req_q.store, 1, "store pulse");
    chk(nv_req_q.key, 32'h3939_6b61, "stored key");
    cmd(dcs_pkg::OP_UPLOAD, 4'h0, 1'b0);
    chk(upload_go_q, 1, "not yet locked");
    pwr;
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_LOCKED], 1, "locked at boot");
    rdr(dcs_pkg::REG_PTYPE, v);
    chk(v, {29'h0, dcs_pkg::PT_CW_CCW}, "type retained");
    cmd(dcs_pkg::OP_UPLOAD, 4'h0, 1'b0);
    chk(upload_go_q, 0, "locked upload");
    cmd(dcs_pkg::OP_DELETE, 4'h5, 1'b1);
    chk(nv_req_q.seg_erase, 0, "locked delete");
    cmd(dcs_pkg::OP_PAUSE, 4'h0, 1'b0);
    chk(buf_exec_en, 0, "locked pause");
    cmd(dcs_pkg::OP_RESUME, 4'h0, 1'b0);
    wrr(dcs_pkg::REG_KEY, 32'h2139_6b61);
    cmd(dcs_pkg::OP_KEY, 4'h0, 1'b0);
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_REFUSED], 1, "bad char key");
    wrr(dcs_pkg::REG_KEY, 32'h3939_6b61);
    cmd(dcs_pkg::OP_KEY, 4'h0, 1'b0);
    cmd(dcs_pkg::OP_SAVE, 4'h0, 1'b0);
    chk(save_go_q, 1, "unlocked save");
    pwr;
    wrr(dcs_pkg::REG_KEY, dcs_pkg::KEY_DEFAULT);
    cmd(dcs_pkg::OP_KEY, 4'h0, 1'b0);
    chk(nv_req_q.erase_all, 1, "wipe on default");
    pwr;
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_LOCKED], 0, "open after wipe");
    $display("test lock done");
  endtask
  task t_call;
    @(posedge clk);
    cur_seg <= 4'h2;
    cur_line <= 6'h05;
    cmd(dcs_pkg::OP_CALL, 4'h4, 1'b1);
    chk({21'h0, seg_load_q}, {21'h0, 11'h501}, "call load");
    cmd(dcs_pkg::OP_CALL, 4'h0, 1'b0);
    chk({21'h0, seg_load_q}, {21'h0, 11'h486}, "return load");
    cmd(dcs_pkg::OP_CALL, 4'h0, 1'b0);
    chk(line_next_q, 1, "empty return");
    for (int i = 1; i <= 6; i++)
      cmd(dcs_pkg::OP_CALL, 4'(i), 1'b1);
    chk(line_next_q, 1, "sixth call");
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_DEPTH+:3], 5, "depth five");
    $display("test call done");
  endtask
  task t_delete;
    cmd(dcs_pkg::OP_DELETE, 4'hc, 1'b1);
    chk(nv_req_q.seg, 4'hc, "erase seg");
    chk(nv_req_q.seg_erase, 1, "erase pulse");
    @(posedge clk) #1;
    chk(erased, 4'hc, "stored erase");
    cmd(dcs_pkg::OP_DELETE, 4'hd, 1'b1);
    chk(nv_req_q.seg_erase, 0, "out of range");
    rdr(dcs_pkg::REG_STATUS, v);
    chk(v[dcs_pkg::ST_BADARG], 1, "bad arg flag");
    $display("test delete done");
  endtask

  // Main sequence.
  initial begin
    pwr;
    t_pause;
    t_pulse;
    t_lock;
    t_call;
    t_delete;
    tally_and_finish;
  end
endmodule // tb

/* File: verilog/dcs_call_stack.sv */
`timescale 1ns/1ns
module dcs_call_stack (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                push,
  input  wire logic                pop,
  input  wire dcs_pkg::dcs_frame_s push_data,
  output dcs_pkg::dcs_frame_s      top_q,
  output logic                     full,
  output logic                     empty,
  output logic [2:0]               depth_q
);

  // ****************************************************************
  // Frame storage.
  // ****************************************************************
  dcs_pkg::dcs_frame_s mem_q [dcs_pkg::STACK_DEPTH];
  logic [2:0]          depth_d;
  logic                do_push;
  logic                do_pop;

  // Full and empty guard the stack against overflow and underflow.
  assign full    = (depth_q == 3'(dcs_pkg::STACK_DEPTH));
  assign empty   = (depth_q == 3'h0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty && !push;
  assign depth_d = do_push ? depth_q + 3'h1 :
                   do_pop  ? depth_q - 3'h1 : depth_q;

  // Depth count and frame writes; the top frame is read from a register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      depth_q <= 3'h0;
      top_q   <= '0;
    end else if (ce) begin
      depth_q <= depth_d;
      if (do_push) begin
        mem_q[depth_q] <= push_data;
      end
      // Top register always mirrors the newest frame on the stack.
      if (do_push) begin
        top_q <= push_data;
      end else if (do_pop) begin
        top_q <= (depth_q > 3'h1) ? mem_q[depth_q - 3'h2] : '0;
      end
    end
  end

endmodule // dcs_call_stack

/* File: verilog/dcs_pkg.sv */
package dcs_pkg;

  // ****************************************************************
  // Register map, word offsets on the plain register port.
  // ****************************************************************
  localparam logic [3:0] REG_CMD    = 4'h0; // Command issue, write only.
  localparam logic [3:0] REG_KEY    = 4'h1; // Key code entry buffer.
  localparam logic [3:0] REG_PTYPE  = 4'h2; // Pulse input type.
  localparam logic [3:0] REG_MODE   = 4'h3; // Control mode select.
  localparam logic [3:0] REG_STATUS = 4'h4; // Block state, read only.

  // ****************************************************************
  // Command register fields and opcodes.
  // ****************************************************************
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_ARG_LSB = 4;
  localparam int CMD_HAS_ARG = 8;

  localparam logic [3:0] OP_PAUSE   = 4'h1;
  localparam logic [3:0] OP_RESUME  = 4'h2;
  localparam logic [3:0] OP_KEY     = 4'h3;
  localparam logic [3:0] OP_STORE   = 4'h4;
  localparam logic [3:0] OP_UPLOAD  = 4'h5;
  localparam logic [3:0] OP_SAVE    = 4'h6;
  localparam logic [3:0] OP_DELETE  = 4'h7;
  localparam logic [3:0] OP_CALL    = 4'h8;

  // ****************************************************************
  // Status register fields.
  // ****************************************************************
  localparam int ST_PAUSED  = 0;
  localparam int ST_LOCKED  = 1;
  localparam int ST_PROTECT = 2;
  localparam int ST_FULL    = 3;
  localparam int ST_EMPTY   = 4;
  localparam int ST_DEPTH   = 5;
  localparam int ST_REFUSED = 8;
  localparam int ST_BADARG  = 9;

  // ****************************************************************
  // Pulse types, modes, key and segment limits.
  // ****************************************************************
  localparam logic [2:0] PT_STEP_DIR  = 3'h0;
  localparam logic [2:0] PT_CW_CCW    = 3'h1;
  localparam logic [2:0] PT_AB_QUAD   = 3'h2;
  localparam logic [2:0] PT_STEP_NDIR = 3'h4;
  localparam logic [2:0] PT_BA_QUAD   = 3'h6;
  localparam logic [2:0] PT_RESET     = 3'h0;

  localparam logic [3:0] MODE_PULSE_FOLLOW = 4'h7;
  localparam logic [3:0] MODE_RESET        = 4'h0;

  // Default key "1234", first character in the low byte.
  localparam logic [31:0] KEY_DEFAULT = 32'h3433_3231;

  localparam logic [3:0] SEG_MIN    = 4'h1;
  localparam logic [3:0] SEG_MAX    = 4'hc;
  localparam logic [5:0] LINE_FIRST = 6'h01;
  localparam int         STACK_DEPTH = 5;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    LK_BOOT,
    LK_LOCKED,
    LK_OPEN
  } dcs_lock_e;

  typedef struct packed {
    logic [3:0] seg;
    logic [5:0] line;
  } dcs_frame_s;

  typedef struct packed {
    logic        store;
    logic        erase_all;
    logic        seg_erase;
    logic [3:0]  seg;
    logic [31:0] key;
    logic [2:0]  ptype;
  } dcs_nv_req_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] seg;
    logic [5:0] line;
  } dcs_seg_load_s;

  // True when one key character is A-Z, a-z or 0-9.
  function automatic logic key_char_ok(input logic [7:0] c);
    key_char_ok = (c >= 8'h30 && c <= 8'h39) ||
                  (c >= 8'h41 && c <= 8'h5a) ||
                  (c >= 8'h61 && c <= 8'h7a);
  endfunction

endpackage

/* File: verilog/dcs_sequencer.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module dcs_sequencer (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic [3:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata_q,
  input  wire logic [31:0]            nv_key_in,
  input  wire logic [2:0]             nv_ptype_in,
  output dcs_pkg::dcs_nv_req_s        nv_req_q,
  output logic                        buf_exec_en,
  output logic                        buf_accept,
  input  wire logic [3:0]             cur_seg,
  input  wire logic [5:0]             cur_line,
  output dcs_pkg::dcs_seg_load_s      seg_load_q,
  output logic                        line_next_q,
  output logic                        upload_go_q,
  output logic                        save_go_q,
  input  wire logic                   pulse_a,
  input  wire logic                   pulse_b,
  output logic                        count_up_q,
  output logic                        count_dn_q
);

  // ****************************************************************
  // State.
  // ****************************************************************
  dcs_pkg::dcs_lock_e    lock_q;
  dcs_pkg::dcs_lock_e    lock_d;
  logic                  protect_q;
  logic                  paused_q;
  logic [31:0]           key_buf_q;
  logic [31:0]           pend_key_q;
  logic [31:0]           pend_key_d;
  logic [2:0]            ptype_q;
  logic [3:0]            mode_q;
  logic                  refused_q;
  logic                  badarg_q;
  logic                  pa_q;
  logic                  pb_q;
  dcs_pkg::dcs_frame_s   stk_top;
  logic                  stk_full;
  logic                  stk_empty;
  logic [2:0]            stk_depth;

  // ****************************************************************
  // Command decode.
  // ****************************************************************
  logic [3:0]  op;
  logic [3:0]  arg;
  logic        has_arg;
  logic        cmd_wr;
  logic        key_wr;
  logic        ptype_wr;
  logic        mode_wr;
  logic        is_key;
  logic        is_prot;
  logic        seg_ok;
  logic        key_chars_ok;
  logic        key_match;
  logic        key_dflt;
  logic        locked;
  logic        prot_refuse;
  logic        ptype_ok;
  logic        call_push;
  logic        call_pop;
  logic        key_refuse;
  logic        key_erase;
  logic [2:0]  new_ptype;

  // Field extraction and address decode of a register write.
  assign op       = wdata[dcs_pkg::CMD_OP_LSB +: 4];
  assign arg      = wdata[dcs_pkg::CMD_ARG_LSB +: 4];
  assign has_arg  = wdata[dcs_pkg::CMD_HAS_ARG];
  assign cmd_wr   = wr && (addr == dcs_pkg::REG_CMD);
  assign key_wr   = wr && (addr == dcs_pkg::REG_KEY);
  assign ptype_wr = wr && (addr == dcs_pkg::REG_PTYPE);
  assign mode_wr  = wr && (addr == dcs_pkg::REG_MODE);
  assign is_key   = cmd_wr && (op == dcs_pkg::OP_KEY);
  assign is_prot  = cmd_wr && ((op == dcs_pkg::OP_UPLOAD) ||
                               (op == dcs_pkg::OP_SAVE) ||
                               (op == dcs_pkg::OP_DELETE));
  assign seg_ok   = has_arg && (arg >= dcs_pkg::SEG_MIN) &&
                    (arg <= dcs_pkg::SEG_MAX);
  assign locked   = (lock_q != dcs_pkg::LK_OPEN);

  assign key_chars_ok = dcs_pkg::key_char_ok(key_buf_q[7:0]) &&
                        dcs_pkg::key_char_ok(key_buf_q[15:8]) &&
                        dcs_pkg::key_char_ok(key_buf_q[23:16]) &&
                        dcs_pkg::key_char_ok(key_buf_q[31:24]);
  assign key_match = (key_buf_q == nv_key_in);
  assign key_dflt  = (key_buf_q == dcs_pkg::KEY_DEFAULT);

  assign key_erase  = is_key && key_chars_ok && locked && !key_match &&
                      key_dflt;
  assign key_refuse = is_key && (!key_chars_ok ||
                      (locked && !key_match && !key_dflt));

  assign prot_refuse = is_prot && locked;

  assign new_ptype = wdata[2:0];
  assign ptype_ok  = (wdata[31:3] == 29'h0000_0000) &&
                     ((new_ptype == dcs_pkg::PT_STEP_DIR) ||
                      (new_ptype == dcs_pkg::PT_CW_CCW) ||
                      (new_ptype == dcs_pkg::PT_AB_QUAD) ||
                      (new_ptype == dcs_pkg::PT_STEP_NDIR) ||
                      (new_ptype == dcs_pkg::PT_BA_QUAD));

  // Calls beyond five deep are ignored.
  assign call_push = cmd_wr && (op == dcs_pkg::OP_CALL) && seg_ok &&
                     !stk_full;
  assign call_pop  = cmd_wr && (op == dcs_pkg::OP_CALL) && !has_arg &&
                     !stk_empty;

  // Queue always takes new commands; execution gated by pause.
  assign buf_accept  = 1'b1;
  assign buf_exec_en = !paused_q;

  // ****************************************************************
  // Lock state and pending key.
  // ****************************************************************
  // Lock state follows boot evaluation and key commands.
  always_comb begin
    lock_d     = lock_q;
    pend_key_d = pend_key_q;
    case (lock_q)
      // Power-up locks when stored key is not default.
      dcs_pkg::LK_BOOT: begin
        lock_d     = (nv_key_in == dcs_pkg::KEY_DEFAULT) ?
                     dcs_pkg::LK_OPEN : dcs_pkg::LK_LOCKED;
        pend_key_d = nv_key_in;
      end
      dcs_pkg::LK_LOCKED: begin
        if (is_key && key_chars_ok && (key_match || key_dflt)) begin
          lock_d     = dcs_pkg::LK_OPEN;
          pend_key_d = key_dflt ? dcs_pkg::KEY_DEFAULT : pend_key_q;
        end
      end
      dcs_pkg::LK_OPEN: begin
        // New key only pending until the store command.
        if (is_key && key_chars_ok) begin
          pend_key_d = key_buf_q;
        end
      end
      default: begin
        lock_d = dcs_pkg::LK_BOOT;
      end
    endcase
  end

  // Lock, protection, pause and configuration registers.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_q     <= dcs_pkg::LK_BOOT;
      protect_q  <= 1'b1;
      pend_key_q <= dcs_pkg::KEY_DEFAULT;
      paused_q   <= 1'b0;
      key_buf_q  <= 32'h0000_0000;
      ptype_q    <= dcs_pkg::PT_RESET;
      mode_q     <= dcs_pkg::MODE_RESET;
    end else if (ce) begin
      lock_q     <= lock_d;
      pend_key_q <= pend_key_d;
      // Default stored key leaves the program unprotected.
      if (lock_q == dcs_pkg::LK_BOOT) begin
        protect_q <= (nv_key_in != dcs_pkg::KEY_DEFAULT);
        ptype_q   <= nv_ptype_in;
      end else if (ptype_wr && ptype_ok) begin
        ptype_q <= new_ptype;
      end
      if (cmd_wr && (op == dcs_pkg::OP_PAUSE)) begin
        paused_q <= 1'b1;
      end else if (cmd_wr && (op == dcs_pkg::OP_RESUME)) begin
        paused_q <= 1'b0;
      end
      if (key_wr) begin
        key_buf_q <= wdata;
      end
      if (mode_wr) begin
        mode_q <= wdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Command results: storage requests, program actions, segment flow.
  // ****************************************************************
  // Result flags of the last command and the one-cycle action pulses.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refused_q   <= 1'b0;
      badarg_q    <= 1'b0;
      nv_req_q    <= '0;
      upload_go_q <= 1'b0;
      save_go_q   <= 1'b0;
      seg_load_q  <= '0;
      line_next_q <= 1'b0;
    end else if (ce) begin
      if (cmd_wr || ptype_wr) begin
        refused_q <= prot_refuse || key_refuse || (ptype_wr && !ptype_ok);
        badarg_q  <= cmd_wr && (op == dcs_pkg::OP_DELETE) && !seg_ok;
      end
      // Store writes the pending key to storage.
      nv_req_q.store     <= cmd_wr && (op == dcs_pkg::OP_STORE);
      nv_req_q.key       <= pend_key_q;
      nv_req_q.ptype     <= ptype_q;
      nv_req_q.erase_all <= key_erase;
      // Segment delete of segments 1 to 12.
      nv_req_q.seg_erase <= is_prot && !locked &&
                            (op == dcs_pkg::OP_DELETE) && seg_ok;
      nv_req_q.seg       <= arg;
      // Protected operations and the key wipe depend on the lock.
      upload_go_q <= is_prot && !locked && (op == dcs_pkg::OP_UPLOAD);
      save_go_q   <= is_prot && !locked && (op == dcs_pkg::OP_SAVE);
      // Call loads line 1; return reloads the line after the caller.
      seg_load_q.valid <= call_push || call_pop;
      seg_load_q.seg   <= call_pop ? stk_top.seg : arg;
      seg_load_q.line  <= call_pop ? stk_top.line + 6'h01 :
                          dcs_pkg::LINE_FIRST;
      // Ignored call or return steps to the next line.
      line_next_q <= cmd_wr && (op == dcs_pkg::OP_CALL) &&
                     ((has_arg && !call_push) || (!has_arg && stk_empty));
    end
  end

  // ****************************************************************
  // Call stack.
  // ****************************************************************
  dcs_pkg::dcs_frame_s push_frame;

  // Frame pushed by a call: the position of the calling line.
  assign push_frame.seg  = cur_seg;
  assign push_frame.line = cur_line;

  dcs_call_stack u_stack (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .push      (call_push),
    .pop       (call_pop),
    .push_data (push_frame),
    .top_q     (stk_top),
    .full      (stk_full),
    .empty     (stk_empty),
    .depth_q   (stk_depth)
  );

  // ****************************************************************
  // Pulse input decoding.
  // ****************************************************************
  logic a_rise;
  logic b_rise;
  logic q_move;
  logic q_fwd;
  logic dec_up;
  logic dec_dn;
  logic follow;

  assign follow = (mode_q == dcs_pkg::MODE_PULSE_FOLLOW);
  assign a_rise = pulse_a && !pa_q;
  assign b_rise = pulse_b && !pb_q;
  // Exactly one quadrature line changed; two at once is not counted.
  assign q_move = (pulse_a ^ pa_q) ^ (pulse_b ^ pb_q);
  assign q_fwd  = pulse_a ^ pb_q;

  always_comb begin
    dec_up = 1'b0;
    dec_dn = 1'b0;
    case (ptype_q)
      dcs_pkg::PT_STEP_DIR: begin
        dec_up = a_rise && !pulse_b;
        dec_dn = a_rise && pulse_b;
      end
      dcs_pkg::PT_STEP_NDIR: begin
        dec_up = a_rise && pulse_b;
        dec_dn = a_rise && !pulse_b;
      end
      dcs_pkg::PT_CW_CCW: begin
        dec_up = a_rise && !b_rise;
        dec_dn = b_rise && !a_rise;
      end
      dcs_pkg::PT_AB_QUAD: begin
        dec_up = q_move && q_fwd;
        dec_dn = q_move && !q_fwd;
      end
      dcs_pkg::PT_BA_QUAD: begin
        dec_up = q_move && !q_fwd;
        dec_dn = q_move && q_fwd;
      end
      default: begin
        dec_up = 1'b0;
        dec_dn = 1'b0;
      end
    endcase
  end

  // Counts only leave the block in pulse-follow mode.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pa_q       <= 1'b0;
      pb_q       <= 1'b0;
      count_up_q <= 1'b0;
      count_dn_q <= 1'b0;
    end else if (ce) begin
      pa_q       <= pulse_a;
      pb_q       <= pulse_b;
      count_up_q <= follow && dec_up;
      count_dn_q <= follow && dec_dn;
    end
  end

  // ****************************************************************
  // Register read port.
  // ****************************************************************
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  assign status_w = {22'h00_0000, badarg_q, refused_q, stk_depth,
                     stk_empty, stk_full, protect_q, locked, paused_q};
  assign rd_mux = (addr == dcs_pkg::REG_KEY)    ? key_buf_q :
                  (addr == dcs_pkg::REG_PTYPE)  ? {29'h0, ptype_q} :
                  (addr == dcs_pkg::REG_MODE)   ? {28'h0, mode_q} :
                  (addr == dcs_pkg::REG_STATUS) ? status_w : 32'h0000_0000;

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // dcs_sequencer
